// >>> verilog/ffm_fault_manager.v
`include "ffm_map.vh"
`default_nettype none
// Operation
// [R01] short trip after blanking ends pulse
// [R02] short blanking ends 50 ns before over-current
// [R03] each short trip increments consecutive count
// [R04] count past limit triggers latch or restart
// [R05] transition selects raised trip levels
// [R06] raise at first pulse, hold 1 ms after
// [R07] halted fault sources bias until on threshold
// [R08] resume bias at off threshold
// [R09] bias repeats until exit condition
// [R10] auto fault: drives low for retry interval
// [R11] restart after interval at supply on
// [R12] latch waits for cycle end, stops drives
// [R13] latch in skip: no more pulses
// [R14] latched: watch line, keep bias
// [R15] thermal: non-latching stop until hysteresis clears
// [R16] reset or line removal clears thermal
// [R17] latch cleared only by brownout or reset
// [R18] over-current count up 2, down 1
// [R19] options sampled once at power-up
// [R20] short count clears on clean cycle, restart
module ffm_fault_manager
#(
    parameter SC_LIMIT = `FFM_SC_LIMIT,
    parameter OC_FULL = `FFM_OC_FULL,
    parameter OC_BLANK_CYC = (`FFM_OC_BLANK_NS * `FFM_CLK_MHZ) / 1000,
    parameter RAISE_HOLD_CYC = `FFM_RAISE_HOLD_CYC,
    parameter RETRY_BASE_CYC = `FFM_RETRY_BASE_CYC
)
(
    input wire CLK,
    input wire RST_N,
    input wire PWM_ON,
    input wire ACTIVE_CLAMP_MODE,
    input wire SKIP_MODE,
    input wire MODE_TRANSITION,
    input wire SC_TRIP,
    input wire OC_TRIP,
    input wire VCC_ON,
    input wire VCC_OFF,
    input wire VCC_RESET,
    input wire HV_PRESENT,
    input wire LINE_REMOVED,
    input wire BROWNOUT,
    input wire AC_APPLIED,
    input wire OVER_TEMP,
    input wire TEMP_CLEAR,
    input wire [1:0] RETRY_SEL,
    input wire SC_LATCH_SEL,
    input wire OC_LATCH_SEL,
    output reg MAIN_GATE_DRIVE,
    output reg CLAMP_GATE_DRIVE,
    output reg SC_BLANK_DONE,
    output reg OC_BLANK_DONE,
    output reg RAISED_LEVELS,
    output reg HV_SOURCE,
    output reg SOFT_START,
    output reg LATCHED,
    output reg [2:0] FAULT_STATE
);
// ----------------------------------------
// input synchronisers
// ----------------------------------------
    localparam NIN = 19;
    wire [NIN-1:0] raw_in;
    reg [NIN-1:0] sync1_reg;
    reg [NIN-1:0] sync2_reg;
    assign raw_in = {RETRY_SEL, SC_LATCH_SEL, OC_LATCH_SEL, PWM_ON,
        ACTIVE_CLAMP_MODE, SKIP_MODE, MODE_TRANSITION, SC_TRIP, OC_TRIP,
        VCC_ON, VCC_OFF, VCC_RESET, HV_PRESENT, LINE_REMOVED, BROWNOUT,
        AC_APPLIED, OVER_TEMP, TEMP_CLEAR};
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            sync1_reg <= {NIN{1'b0}};
            sync2_reg <= {NIN{1'b0}};
        end
        else
        begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire pwm = sync2_reg[14];
    wire skip = sync2_reg[12];
    wire trans = sync2_reg[11];
    wire sc_t = sync2_reg[10];
    wire oc_t = sync2_reg[9];
    wire vcc_on = sync2_reg[8];
    wire vcc_off = sync2_reg[7];
    wire vcc_rst = sync2_reg[6];
    wire hv = sync2_reg[5];
    wire line_rm = sync2_reg[4];
    wire brown = sync2_reg[3];
    wire ac = sync2_reg[2];
    wire otemp = sync2_reg[1];
    wire tclr = sync2_reg[0];

// ----------------------------------------
// power-up option capture
// ----------------------------------------
    reg opt_done_reg;
    reg [1:0] retry_sel_reg;
    reg sc_latch_reg;
    reg oc_latch_reg;
    always @(posedge CLK)
    begin
        if (!RST_N)
            opt_done_reg <= 1'b0;
        else if (vcc_on)
            opt_done_reg <= 1'b1;
        if (!opt_done_reg)
        begin
            retry_sel_reg <= sync2_reg[18:17]; // [R19]
            sc_latch_reg <= sync2_reg[16];
            oc_latch_reg <= sync2_reg[15];
        end
    end
// ----------------------------------------
// blanking from pulse rise
// ----------------------------------------
    localparam SC_BLANK_CYC = OC_BLANK_CYC - `FFM_SC_BLANK_EARLY_CYC;
    reg pwm_d_reg;
    reg [7:0] blank_cnt_reg;
    wire pulse_rise = pwm && !pwm_d_reg;
    wire pulse_fall = !pwm && pwm_d_reg;
    wire sc_blank_ok = blank_cnt_reg >= SC_BLANK_CYC[7:0]; // [R02]
    wire oc_blank_ok = blank_cnt_reg >= OC_BLANK_CYC[7:0];
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            pwm_d_reg <= 1'b0;
            blank_cnt_reg <= 8'h00;
        end
        else
        begin
            pwm_d_reg <= pwm;
            if (pulse_rise || !pwm)
                blank_cnt_reg <= 8'h00;
            else if (pwm && blank_cnt_reg != 8'hFF)
                blank_cnt_reg <= blank_cnt_reg + 8'h01;
        end
    end
    wire sc_hit = pwm && sc_blank_ok && sc_t; // [R01]
    wire oc_hit = pwm && oc_blank_ok && oc_t;

// ----------------------------------------
// per-cycle trip memory and counters
// ----------------------------------------
    reg cyc_sc_reg;
    reg cyc_oc_reg;
    reg [7:0] sc_cnt_reg;
    reg [15:0] oc_cnt_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    wire run = state_reg == `FFM_ST_RUN;
    wire restart;
    always @(posedge CLK)
    begin
        if (!RST_N || pulse_rise)
        begin
            cyc_sc_reg <= 1'b0;
            cyc_oc_reg <= 1'b0;
        end
        else
        begin
            if (sc_hit)
                cyc_sc_reg <= 1'b1;
            if (oc_hit)
                cyc_oc_reg <= 1'b1;
        end
    end
    wire sc_now = cyc_sc_reg || sc_hit;
    wire oc_now = cyc_oc_reg || oc_hit;
    always @(posedge CLK)
    begin
        if (!RST_N || restart)
            sc_cnt_reg <= 8'h00; // [R20]
        else if (pulse_fall && run)
        begin
            if (sc_now && sc_cnt_reg != 8'hFF)
                sc_cnt_reg <= sc_cnt_reg + 8'h01; // [R03]
            else if (!sc_now)
                sc_cnt_reg <= 8'h00; // [R20]
        end
    end
    always @(posedge CLK)
    begin
        if (!RST_N || restart)
            oc_cnt_reg <= 16'h0000;
        else if (pulse_fall && run)
        begin
            if (oc_now)
                oc_cnt_reg <= oc_cnt_reg + `FFM_OC_UP; // [R18]
            else if (oc_cnt_reg != 16'h0000)
                oc_cnt_reg <= oc_cnt_reg - `FFM_OC_DOWN; // [R18]
        end
    end
    wire sc_fault = sc_cnt_reg > SC_LIMIT[7:0]; // [R04]
    wire oc_fault = oc_cnt_reg >= OC_FULL[15:0]; // [R18]
    wire fault_latch = (sc_fault && sc_latch_reg) || (oc_fault && oc_latch_reg);

// ----------------------------------------
// raised trip levels around transitions
// ----------------------------------------
    reg trans_arm_reg;
    reg [27:0] hold_cnt_reg;
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            trans_arm_reg <= 1'b0;
            hold_cnt_reg <= 28'h0000000;
            RAISED_LEVELS <= 1'b0;
        end
        else
        begin
            trans_arm_reg <= trans;
            if (trans && pulse_rise)
                RAISED_LEVELS <= 1'b1; // [R05]
            if (trans)
                hold_cnt_reg <= 28'h0000000;
            else if (RAISED_LEVELS && trans_arm_reg == 1'b0)
            begin
                if (hold_cnt_reg >= RAISE_HOLD_CYC[27:0] - 28'h0000001)
                    RAISED_LEVELS <= 1'b0; // [R06]
                else
                    hold_cnt_reg <= hold_cnt_reg + 28'h0000001;
            end
        end
    end

// ----------------------------------------
// fault state machine
// ----------------------------------------
    reg [31:0] retry_cnt_reg;
    wire [31:0] retry_len = RETRY_BASE_CYC << retry_sel_reg; // [R19]
    wire retry_done = retry_cnt_reg >= retry_len;
    wire bias_exit = !hv || vcc_rst || ac; // [R09]
    assign restart = state_reg == `FFM_ST_WAIT && vcc_on;
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            `FFM_ST_RUN:
                if (otemp)
                    state_next = `FFM_ST_THERM; // [R15]
                else if (fault_latch)
                    state_next = skip ? `FFM_ST_LATCH : `FFM_ST_STOP; // [R13]
                else if (sc_fault || oc_fault)
                    state_next = `FFM_ST_RETRY; // [R10]
            `FFM_ST_STOP:
                if (!pwm)
                    state_next = `FFM_ST_LATCH; // [R12]
            `FFM_ST_RETRY:
                if (vcc_rst || !hv)
                    state_next = `FFM_ST_WAIT;
                else if (retry_done || ac)
                    state_next = `FFM_ST_WAIT; // [R09]
            `FFM_ST_LATCH:
                if (brown || vcc_rst)
                    state_next = `FFM_ST_WAIT; // [R17]
            `FFM_ST_THERM:
                if (tclr || vcc_rst || line_rm)
                    state_next = `FFM_ST_WAIT; // [R16]
            `FFM_ST_WAIT:
                if (vcc_on)
                    state_next = `FFM_ST_RUN; // [R11]
            default:
                state_next = `FFM_ST_WAIT;
        endcase
    end
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_reg <= `FFM_ST_WAIT;
            retry_cnt_reg <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == `FFM_ST_RETRY)
                retry_cnt_reg <= retry_cnt_reg + 32'h00000001;
            else
                retry_cnt_reg <= 32'h00000000;
        end
    end

// ----------------------------------------
// bias cycle while halted by a fault
// ----------------------------------------
    wire bias_src;
    wire halted = (state_reg == `FFM_ST_RETRY || state_reg == `FFM_ST_WAIT)
        || (state_reg == `FFM_ST_LATCH && !line_rm); // [R14]
    ffm_bias_cycle u_bias
    (
        .clk(CLK),
        .rst_n(RST_N),
        .active(halted && !bias_exit),
        .vcc_on(vcc_on),
        .vcc_off(vcc_off),
        .source_reg(bias_src)
    );

// ----------------------------------------
// registered outputs
// ----------------------------------------
    wire drive_ok = run || state_reg == `FFM_ST_STOP;
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            MAIN_GATE_DRIVE <= 1'b0;
            CLAMP_GATE_DRIVE <= 1'b0;
            SC_BLANK_DONE <= 1'b0;
            OC_BLANK_DONE <= 1'b0;
            HV_SOURCE <= 1'b0;
            SOFT_START <= 1'b0;
            LATCHED <= 1'b0;
            FAULT_STATE <= `FFM_ST_WAIT;
        end
        else
        begin
            MAIN_GATE_DRIVE <= drive_ok && pwm && !sc_now; // [R01]
            CLAMP_GATE_DRIVE <= drive_ok && !pwm && sync2_reg[13]; // [R10]
            SC_BLANK_DONE <= pwm && sc_blank_ok;
            OC_BLANK_DONE <= pwm && oc_blank_ok;
            HV_SOURCE <= bias_src;
            SOFT_START <= restart;
            LATCHED <= state_reg == `FFM_ST_LATCH;
            FAULT_STATE <= state_reg;
        end
    end
endmodule // ffm_fault_manager
`default_nettype wire

// >>> verilog/ffm_map.vh
`ifndef FFM_MAP_VH
`define FFM_MAP_VH
// ----------------------------------------
// timing, counts at 200 MHz
// ----------------------------------------
`define FFM_CLK_MHZ 200
`define FFM_SC_BLANK_EARLY_NS 50
`define FFM_SC_BLANK_EARLY_CYC ((`FFM_SC_BLANK_EARLY_NS * `FFM_CLK_MHZ) / 1000)
`define FFM_OC_BLANK_NS 200
`define FFM_RAISE_HOLD_US 1000
`define FFM_RAISE_HOLD_CYC (`FFM_RAISE_HOLD_US * `FFM_CLK_MHZ)
`define FFM_RETRY_BASE_MS 200
`define FFM_RETRY_BASE_CYC (`FFM_RETRY_BASE_MS * 1000 * `FFM_CLK_MHZ)
// ----------------------------------------
// counter defaults
// ----------------------------------------
`define FFM_SC_LIMIT 5
`define FFM_OC_FULL 5000
`define FFM_OC_UP 16'h0002
`define FFM_OC_DOWN 16'h0001
// ----------------------------------------
// fault states
// ----------------------------------------
`define FFM_ST_RUN 3'h0
`define FFM_ST_STOP 3'h1
`define FFM_ST_RETRY 3'h2
`define FFM_ST_LATCH 3'h3
`define FFM_ST_THERM 3'h4
`define FFM_ST_WAIT 3'h5
`endif

// >>> verilog/ffm_bias_cycle.v
`include "ffm_map.vh"
`default_nettype none
// ----------------------------------------
// supply bias cycle: charge from off to on threshold
// ----------------------------------------
module ffm_bias_cycle
(
    input wire clk,
    input wire rst_n,
    input wire active,
    input wire vcc_on,
    input wire vcc_off,
    output reg source_reg
);
    reg source_next;

    always @*
    begin
        source_next = source_reg;
        if (!active)
            source_next = 1'b0;
        else if (vcc_on)
            source_next = 1'b0; // [R07]
        else if (vcc_off)
            source_next = 1'b1; // [R08]
    end

    always @(posedge clk)
    begin
        if (!rst_n)
            source_reg <= 1'b0;
        else
            source_reg <= source_next;
    end
endmodule // ffm_bias_cycle
`default_nettype wire

// >>> dv/ffm_fault_chk.sv
`default_nettype none
module ffm_fault_chk
(
    input wire CLK,
    input wire RST_N,
    input wire MODE_TRANSITION,
    input wire TEMP_CLEAR,
    input wire VCC_RESET,
    input wire LINE_REMOVED,
    input wire BROWNOUT,
    input wire MAIN_GATE_DRIVE,
    input wire CLAMP_GATE_DRIVE,
    input wire SC_BLANK_DONE,
    input wire OC_BLANK_DONE,
    input wire RAISED_LEVELS,
    input wire HV_SOURCE,
    input wire SOFT_START,
    input wire LATCHED,
    input wire [2:0] FAULT_STATE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // stopping state may still finish a pulse, so it is not halted
    wire halt = FAULT_STATE > 3'h1;
    sequence latch_quiet;
        (LATCHED && !BROWNOUT && !VCC_RESET) [*4];
    endsequence
    sequence therm_quiet;
        (FAULT_STATE == 3'h4 && !TEMP_CLEAR && !VCC_RESET
            && !LINE_REMOVED) [*4];
    endsequence
    drives_off_a: assert property (halt ##1 halt |->
        !MAIN_GATE_DRIVE && !CLAMP_GATE_DRIVE) else $error("drive in halt");
    latch_flag_a: assert property ($rose(LATCHED) |->
        ##[0:2] FAULT_STATE == 3'h3) else $error("latched flag w/o state");
    bias_halted_a: assert property (HV_SOURCE |->
        FAULT_STATE != 3'h0) else $error("bias while running");
    blank_order_a: assert property ($rose(OC_BLANK_DONE) |->
        SC_BLANK_DONE) else $error("short blank not first");
    soft_pulse_a: assert property (SOFT_START |=> !SOFT_START)
        else $error("soft start too long");
    latch_hold_a: assert property (latch_quiet |=> LATCHED)
        else $error("latch cleared without cause");
    raise_hold_a: assert property (RAISED_LEVELS &&
        $fell(MODE_TRANSITION) |=> RAISED_LEVELS [*8])
        else $error("raised levels dropped early");
    therm_hold_a: assert property (therm_quiet |=>
        FAULT_STATE == 3'h4) else $error("thermal left early");
endmodule // ffm_fault_chk
bind ffm_fault_manager ffm_fault_chk u_chk (.CLK(CLK), .RST_N(RST_N),
    .MODE_TRANSITION(MODE_TRANSITION), .TEMP_CLEAR(TEMP_CLEAR),
    .VCC_RESET(VCC_RESET), .LINE_REMOVED(LINE_REMOVED),
    .BROWNOUT(BROWNOUT), .MAIN_GATE_DRIVE(MAIN_GATE_DRIVE),
    .CLAMP_GATE_DRIVE(CLAMP_GATE_DRIVE), .SC_BLANK_DONE(SC_BLANK_DONE),
    .OC_BLANK_DONE(OC_BLANK_DONE), .RAISED_LEVELS(RAISED_LEVELS),
    .HV_SOURCE(HV_SOURCE), .SOFT_START(SOFT_START), .LATCHED(LATCHED),
    .FAULT_STATE(FAULT_STATE));
`default_nettype wire

// >>> dv/ffm_drv_model.sv
`default_nettype none
module ffm_drv_model
(
    input wire logic clk,
    input wire logic main_gate,
    input wire logic hv_source,
    input wire logic aux_ok,
    input wire logic sc_en,
    input wire logic oc_en,
    output logic sc_trip,
    output logic oc_trip,
    output logic vcc_on,
    output logic vcc_off
);
    timeunit 1ns;
    timeprecision 1ps;
    int on_cnt = 0;
    int vcc = 40;
    always @(posedge clk)
    begin
        on_cnt <= main_gate ? on_cnt + 1 : 0;
        // aux winding or the hv source refills; with neither, vcc drains
        if (hv_source || aux_ok)
            vcc <= (vcc < 40) ? vcc + 1 : 40;
        else if (vcc > 0)
            vcc <= vcc - 1;
    end
    // ramp crosses the threshold late, past the short blanking window but still inside the over-current one
    assign sc_trip = sc_en && on_cnt > 35;
    assign oc_trip = oc_en && on_cnt > 35;
    assign vcc_on = vcc >= 40;
    assign vcc_off = vcc <= 10;
endmodule // ffm_drv_model
`default_nettype wire

// >>> dv/ffm_fault_manager_tb_top.sv
`default_nettype none
module ffm_fault_manager_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, pwm = 0, acf = 1, skip = 0, trans = 0;
    logic vrst = 0, hv = 1, line_rm = 0, bo = 0, ac = 0, ot = 0, tclr = 0;
    logic [1:0] rsel = 2'h0;
    logic sc_sel = 0, oc_sel = 1, sc_en = 0, oc_en = 0, aux = 1;
    wire sc_t, oc_t, von, voff, mg, cg, scb, ocb, rl, hvs, ss, lat;
    wire [2:0] st;
    int fails = 0, num_checks = 0, cyc = 0;
    initial forever #2.5 clk = ~clk;
    ffm_fault_manager #(.SC_LIMIT(5), .OC_FULL(6), .RAISE_HOLD_CYC(50),
        .RETRY_BASE_CYC(100)) u_dut (.CLK(clk), .RST_N(rst_n),
        .PWM_ON(pwm), .ACTIVE_CLAMP_MODE(acf), .SKIP_MODE(skip),
        .MODE_TRANSITION(trans), .SC_TRIP(sc_t), .OC_TRIP(oc_t),
        .VCC_ON(von), .VCC_OFF(voff), .VCC_RESET(vrst), .HV_PRESENT(hv),
        .LINE_REMOVED(line_rm), .BROWNOUT(bo), .AC_APPLIED(ac),
        .OVER_TEMP(ot), .TEMP_CLEAR(tclr), .RETRY_SEL(rsel),
        .SC_LATCH_SEL(sc_sel), .OC_LATCH_SEL(oc_sel), .MAIN_GATE_DRIVE(mg),
        .CLAMP_GATE_DRIVE(cg), .SC_BLANK_DONE(scb), .OC_BLANK_DONE(ocb),
        .RAISED_LEVELS(rl), .HV_SOURCE(hvs), .SOFT_START(ss),
        .LATCHED(lat), .FAULT_STATE(st));
    ffm_drv_model u_model (.clk(clk), .main_gate(mg), .hv_source(hvs),
        .aux_ok(aux), .sc_en(sc_en), .oc_en(oc_en), .sc_trip(sc_t),
        .oc_trip(oc_t), .vcc_on(von), .vcc_off(voff));
    // ----------------------------------------
    // checking and access tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk_bit(string nm, logic e, logic g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic chk_st(logic [2:0] e);
        num_checks++;
        if (st !== e)
        begin
            fails++;
            $display("wrong value fault_state exp %h got %h", e, st);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_st(logic [2:0] e, int lim);
        for (int i = 0; i < lim && st !== e; i++) tick(1);
        chk_st(e);
    endtask
    // one switching cycle: 48 on, 20 off; trips land after the short blank, before the over-current blank ends
    task automatic pulse(logic sc, logic oc);
        sc_en = sc;
        oc_en = oc;
        pwm = 1;
        tick(38);
        chk_bit("sc_blank_done", 1'b1, scb);
        chk_bit("oc_blank_done", 1'b0, ocb);
        tick(10);
        chk_bit("main_gate_drive", !sc, mg);
        chk_bit("oc_blank_done", 1'b1, ocb);
        sc_en = 0;
        oc_en = 0;
        pwm = 0;
        tick(10);
        if (st === 3'h0) chk_bit("clamp_gate_drive", acf, cg);
        tick(10);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            final_report();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        tick(12);
        chk_st(3'h5);
        chk_bit("latched", 1'b0, lat);
        rst_n = 1;
        wait_st(3'h0, 50);
        pulse(0, 0);
        trans = 1;
        pulse(0, 0);
        chk_bit("raised_levels", 1'b1, rl);
        trans = 0;
        tick(40);
        chk_bit("raised_levels", 1'b1, rl);
        tick(40);
        chk_bit("raised_levels", 1'b0, rl);
        acf = 0;
        pulse(0, 0);
        acf = 1;
        // late option change must be ignored: still auto retry
        sc_sel = 1;
        repeat (4) pulse(1, 0);
        pulse(0, 0);
        repeat (5) pulse(1, 0);
        chk_st(3'h0);
        aux = 0;
        pulse(1, 0);
        wait_st(3'h2, 100);
        tick(60);
        chk_st(3'h2);
        for (int i = 0; i < 100 && hvs !== 1'b1; i++) tick(1);
        chk_bit("hv_source", 1'b1, hvs);
        for (int i = 0; i < 400 && ss !== 1'b1; i++) tick(1);
        chk_bit("soft_start", 1'b1, ss);
        aux = 1;
        wait_st(3'h0, 50);
        repeat (5) pulse(1, 0);
        chk_st(3'h0);
        pulse(0, 1);
        pulse(0, 1);
        pulse(0, 0);
        pulse(0, 1);
        chk_st(3'h0);
        aux = 0;
        pulse(0, 1);
        wait_st(3'h3, 200);
        chk_bit("latched", 1'b1, lat);
        for (int i = 0; i < 100 && hvs !== 1'b1; i++) tick(1);
        chk_bit("hv_source", 1'b1, hvs);
        tick(300);
        chk_st(3'h3);
        line_rm = 1;
        tick(60);
        chk_bit("hv_source", 1'b0, hvs);
        chk_st(3'h3);
        aux = 1;
        bo = 1;
        tick(10);
        bo = 0;
        line_rm = 0;
        wait_st(3'h0, 200);
        chk_bit("latched", 1'b0, lat);
        ot = 1;
        wait_st(3'h4, 50);
        pwm = 1;
        tick(40);
        chk_bit("main_gate_drive", 1'b0, mg);
        pwm = 0;
        ot = 0;
        tclr = 1;
        wait_st(3'h0, 100);
        tclr = 0;
        ot = 1;
        wait_st(3'h4, 50);
        ot = 0;
        vrst = 1;
        tick(10);
        vrst = 0;
        wait_st(3'h0, 100);
        ot = 1;
        wait_st(3'h4, 50);
        ot = 0;
        line_rm = 1;
        tick(10);
        line_rm = 0;
        wait_st(3'h0, 100);
        // latching fault in skip mode goes straight to latched
        skip = 1;
        repeat (3) pulse(0, 1);
        wait_st(3'h3, 50);
        chk_bit("latched", 1'b1, lat);
        skip = 0;
        vrst = 1;
        tick(10);
        vrst = 0;
        wait_st(3'h0, 200);
        final_report();
    end
endmodule // ffm_fault_manager_tb_top
`default_nettype wire
